// >>> srs_pkg.sv
package srs_pkg;
  // ==========================================================
  // Widths and depths
  localparam int STB_W        = 8;
  localparam int EVT_W        = 16;
  localparam int ESR_W        = 8;
  localparam int MSG_W        = 8;
  localparam int OUTQ_DEPTH   = 16;
  localparam int ERRQ_DEPTH   = 10;
  // ==========================================================
  // Status byte bit positions
  localparam int STB_MEAS_BIT = 0;
  localparam int STB_EAV_BIT  = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT  = 4;
  localparam int STB_ESB_BIT  = 5;
  localparam int STB_RQS_BIT  = 6;
  localparam int STB_OPER_BIT = 7;
  // ==========================================================
  // Event set indices
  localparam int SET_MEAS     = 0;
  localparam int SET_QUES     = 1;
  localparam int SET_OPER     = 2;
  localparam int NUM_SETS     = 3;
  // ==========================================================
  // Reset values
  localparam logic [STB_W-1:0] SRE_RESET = 8'h00;
  localparam logic [EVT_W-1:0] ENA_RESET = 16'h0000;
  localparam logic [ESR_W-1:0] ESE_RESET = 8'h00;
  // Summary bits that feed the master summary (bit 6 excluded)
  localparam logic [STB_W-1:0] SUM_MASK  = 8'hBF;
endpackage

// >>> srs_fifo.sv
`timescale 1ns/1ps
// ==========================================================
// Small message queue with registered read data
module srs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             clear_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] pop_data_o,
  output logic                  empty_o,
  output logic                  full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic [WIDTH-1:0] data_reg;
  wire              do_push = push_i && (cnt_reg != (AW+1)'(DEPTH));
  wire              do_pop  = pop_i && (cnt_reg != '0);
  wire [AW-1:0]     wr_inc  = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
  wire [AW-1:0]     rd_inc  = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;

  assign pop_data_o = data_reg;
  assign empty_o    = (cnt_reg == '0);
  assign full_o     = (cnt_reg == (AW+1)'(DEPTH));

  // Storage write
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_reg] <= push_data_i;
    end
  end

  // Pointers, count and registered read word
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      data_reg <= '0;
    end else begin
      if (do_push) wr_reg <= wr_inc;
      if (do_pop) begin
        rd_reg   <= rd_inc;
        data_reg <= mem_reg[rd_reg];
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// >>> srs_status.sv
`timescale 1ns/1ps
module srs_status
  import srs_pkg::*;
#(
  parameter int EVT_WIDTH = srs_pkg::EVT_W,
  parameter int MSGW      = srs_pkg::MSG_W
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    clear_status_i,
  input  wire logic                    preset_i,
  input  wire logic [EVT_WIDTH-1:0]    meas_cond_i,
  input  wire logic [EVT_WIDTH-1:0]    ques_cond_i,
  input  wire logic [EVT_WIDTH-1:0]    oper_cond_i,
  input  wire logic [srs_pkg::ESR_W-1:0] std_event_i,
  input  wire logic                    evt_read_i,
  input  wire logic [1:0]              evt_read_sel_i,
  input  wire logic                    ena_write_i,
  input  wire logic [1:0]              ena_sel_i,
  input  wire logic [EVT_WIDTH-1:0]    ena_wdata_i,
  input  wire logic                    ese_write_i,
  input  wire logic [srs_pkg::ESR_W-1:0] ese_wdata_i,
  input  wire logic                    std_read_i,
  input  wire logic                    sre_write_i,
  input  wire logic [srs_pkg::STB_W-1:0] sre_wdata_i,
  input  wire logic                    out_push_i,
  input  wire logic [MSGW-1:0]         out_data_i,
  input  wire logic                    out_pop_i,
  input  wire logic                    err_push_i,
  input  wire logic [MSGW-1:0]         err_data_i,
  input  wire logic                    err_pop_i,
  input  wire logic                    serial_poll_i,
  output logic      [EVT_WIDTH-1:0]    cond_rdata_o,
  output logic      [EVT_WIDTH-1:0]    evt_rdata_o,
  output logic      [EVT_WIDTH-1:0]    ena_rdata_o,
  output logic      [srs_pkg::ESR_W-1:0] std_evt_rdata_o,
  output logic      [srs_pkg::ESR_W-1:0] ese_rdata_o,
  output logic      [srs_pkg::STB_W-1:0] sre_rdata_o,
  output logic      [srs_pkg::STB_W-1:0] stb_query_o,
  output logic      [srs_pkg::STB_W-1:0] poll_byte_o,
  output logic      [MSGW-1:0]         out_rdata_o,
  output logic      [MSGW-1:0]         err_rdata_o,
  output logic                         err_full_o,
  output logic                         srq_o
);
  import srs_pkg::*;

  // ==========================================================
  // Condition capture and edge detection
  logic [EVT_WIDTH-1:0] cond_reg [NUM_SETS];
  logic [EVT_WIDTH-1:0] evt_reg  [NUM_SETS];
  logic [EVT_WIDTH-1:0] ena_reg  [NUM_SETS];
  logic [EVT_WIDTH-1:0] cond_in  [NUM_SETS];
  logic                 new_reg  [NUM_SETS];
  logic [NUM_SETS-1:0]  set_sum;

  // Standard set and request state
  logic [ESR_W-1:0]     std_reg;
  logic [ESR_W-1:0]     ese_reg;
  logic [STB_W-1:0]     sre_reg;
  logic                 rqs_reg;
  logic [STB_W-1:0]     sum_prev_reg;
  logic [STB_W-1:0]     stb_query_reg;
  logic [STB_W-1:0]     poll_reg;

  // Registered read copies
  logic [EVT_WIDTH-1:0] cond_rd_reg;
  logic [EVT_WIDTH-1:0] evt_rd_reg;
  logic [EVT_WIDTH-1:0] ena_rd_reg;
  logic [ESR_W-1:0]     std_rd_reg;
  logic                 srq_reg;
  // Queue status; the full flag is registered for its output
  logic                 out_empty;
  logic                 err_empty;
  logic                 err_full;
  logic                 err_full_reg;

  assign cond_in[SET_MEAS] = meas_cond_i;
  assign cond_in[SET_QUES] = ques_cond_i;
  assign cond_in[SET_OPER] = oper_cond_i;

  // Function selecting a set index from a 2-bit field
  // Code 3 selects no set, so writes aimed at it are dropped
  function automatic logic [NUM_SETS-1:0] set_hit(input logic [1:0] sel);
    set_hit = '0;
    for (int k = 0; k < NUM_SETS; k++) begin
      if (sel == 2'(k)) set_hit[k] = 1'b1;
    end
  endfunction

  wire [NUM_SETS-1:0] evt_rd_hit = evt_read_i ? set_hit(evt_read_sel_i) : '0;
  wire [NUM_SETS-1:0] ena_wr_hit = ena_write_i ? set_hit(ena_sel_i) : '0;
  // Reads with code 3 return zero instead of unknowns
  wire                rd_sel_ok  = (evt_read_sel_i < 2'(NUM_SETS));
  wire                ena_sel_ok = (ena_sel_i < 2'(NUM_SETS));

  // ==========================================================
  // Per-set event, enable and summary logic
  // Edge detection keeps a steady condition from latching again
  // once a read or clear-status has emptied its event bits
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      wire [EVT_WIDTH-1:0] rise = cond_in[g] & ~cond_reg[g];
      // Summary per set
      assign set_sum[g] = |(evt_reg[g] & ena_reg[g]);
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          cond_reg[g] <= '0;
          evt_reg[g]  <= '0;
          ena_reg[g]  <= EVT_WIDTH'(ENA_RESET);
          new_reg[g]  <= 1'b0;
        end else begin
          cond_reg[g] <= cond_in[g];
          // Enabled rise, even onto an event bit already set
          new_reg[g]  <= |(rise & ena_reg[g]);
          // Rising edge sets win over read clear
          if (clear_status_i || evt_rd_hit[g]) begin
            evt_reg[g] <= rise;
          end else begin
            evt_reg[g] <= evt_reg[g] | rise;
          end
          if (preset_i) begin
            ena_reg[g] <= EVT_WIDTH'(ENA_RESET);
          end else if (ena_wr_hit[g]) begin
            ena_reg[g] <= ena_wdata_i;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Standard event register and its enable
  // Its enable has its own write and is left alone by preset
  wire std_sum = |(std_reg & ese_reg);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      std_reg <= '0;
      ese_reg <= ESE_RESET;
    end else begin
      if (clear_status_i || std_read_i) begin
        std_reg <= std_event_i;
      end else begin
        std_reg <= std_reg | std_event_i;
      end
      if (ese_write_i) begin
        ese_reg <= ese_wdata_i;
      end
    end
  end

  // ==========================================================
  // Message queues
  // Clear-status empties both queues, so message-available
  // drops along with the other summary bits
  srs_fifo #(
    .WIDTH (MSGW),
    .DEPTH (OUTQ_DEPTH)
  ) u_out_q (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .clear_i     (clear_status_i),
    .push_i      (out_push_i),
    .push_data_i (out_data_i),
    .pop_i       (out_pop_i),
    .pop_data_o  (out_rdata_o),
    .empty_o     (out_empty),
    .full_o      ()
  );

  // Error queue refuses pushes once it holds its full depth
  srs_fifo #(
    .WIDTH (MSGW),
    .DEPTH (ERRQ_DEPTH)
  ) u_err_q (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .clear_i     (clear_status_i),
    .push_i      (err_push_i),
    .push_data_i (err_data_i),
    .pop_i       (err_pop_i),
    .pop_data_o  (err_rdata_o),
    .empty_o     (err_empty),
    .full_o      (err_full)
  );

  // ==========================================================
  // Status byte summaries, non-latching
  wire message_available_flag     = ~out_empty;
  wire error_available_flag       = ~err_empty;
  wire standard_event_summary_flag = std_sum;
  wire [STB_W-1:0] sum_bits;
  // Bits 1 and 6 take no summary; bit 6 is filled per read path
  assign sum_bits[STB_MEAS_BIT] = set_sum[SET_MEAS];
  assign sum_bits[1]            = 1'b0;
  assign sum_bits[STB_EAV_BIT]  = error_available_flag;
  assign sum_bits[STB_QUES_BIT] = set_sum[SET_QUES];
  assign sum_bits[STB_MAV_BIT]  = message_available_flag;
  assign sum_bits[STB_ESB_BIT]  = standard_event_summary_flag;
  assign sum_bits[STB_RQS_BIT]  = 1'b0;
  assign sum_bits[STB_OPER_BIT] = set_sum[SET_OPER];

  // New occurrences in the three event sets re-request even while their summary bit stays high
  wire             new_sum              = (new_reg[SET_MEAS] & sre_reg[STB_MEAS_BIT])
                                        | (new_reg[SET_QUES] & sre_reg[STB_QUES_BIT])
                                        | (new_reg[SET_OPER] & sre_reg[STB_OPER_BIT]);

  // Master summary and enabled-summary rise detection
  wire [STB_W-1:0] enabled_sum          = sum_bits & sre_reg & SUM_MASK;
  wire             master_summary_flag  = |enabled_sum;
  wire             enabled_rise         = |(enabled_sum & ~sum_prev_reg) | new_sum;
  wire             service_request_flag = rqs_reg;

  // ==========================================================
  // Service request mask and request flag
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sre_reg      <= SRE_RESET;
      rqs_reg      <= 1'b0;
      sum_prev_reg <= '0;
    end else begin
      // Writing zero masks every summary and so drops the request
      if (sre_write_i) begin
        sre_reg <= sre_wdata_i;
      end
      sum_prev_reg <= enabled_sum;
      // A poll resets only the request flag; the master summary keeps
      // following the enabled summaries until they all clear
      // New rise wins over poll reset
      if (enabled_rise) begin
        rqs_reg <= 1'b1;
      end else if (serial_poll_i || !master_summary_flag || clear_status_i) begin
        rqs_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registered read ports
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stb_query_reg <= '0;
      poll_reg      <= '0;
      srq_reg       <= 1'b0;
      cond_rd_reg   <= '0;
      evt_rd_reg    <= '0;
      ena_rd_reg    <= '0;
      std_rd_reg    <= '0;
      err_full_reg  <= 1'b0;
    end else begin
      // Query shows the master summary, the poll byte the request flag
      stb_query_reg <= sum_bits | {1'b0, master_summary_flag, 6'h00};
      poll_reg      <= sum_bits | {1'b0, service_request_flag, 6'h00};
      srq_reg       <= enabled_rise | (rqs_reg & ~serial_poll_i
                       & master_summary_flag & ~clear_status_i);
      // Event reads see the contents held before the clearing edge
      cond_rd_reg   <= rd_sel_ok ? cond_in[evt_read_sel_i] : '0;
      evt_rd_reg    <= rd_sel_ok ? evt_reg[evt_read_sel_i] : '0;
      ena_rd_reg    <= ena_sel_ok ? ena_reg[ena_sel_i] : '0;
      std_rd_reg    <= std_reg;
      err_full_reg  <= err_full;
    end
  end

  // Outputs come straight from registers
  assign stb_query_o     = stb_query_reg;
  assign poll_byte_o     = poll_reg;
  assign srq_o           = srq_reg;
  assign cond_rdata_o    = cond_rd_reg;
  assign evt_rdata_o     = evt_rd_reg;
  assign ena_rdata_o     = ena_rd_reg;
  assign std_evt_rdata_o = std_rd_reg;
  assign ese_rdata_o     = ese_reg;
  assign sre_rdata_o     = sre_reg;
  assign err_full_o      = err_full_reg;
endmodule

// >>> srs_poll_model.sv
`timescale 1ns/1ps
// ==========================================================
// Bus controller model: answers a request line with a serial poll
module srs_poll_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       enable_i,
  input  wire logic [3:0] pause_i,
  input  wire logic       srq_i,
  input  wire logic [7:0] poll_byte_i,
  output logic            serial_poll_o,
  output logic      [7:0] poll_seen_o,
  output logic      [7:0] poll_count_o
);
  logic [3:0] wait_reg;
  // Wait pause_i cycles of request, strobe once, take the byte at that edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      serial_poll_o <= 1'b0;
      poll_seen_o   <= 8'h00;
      poll_count_o  <= 8'h00;
      wait_reg      <= 4'h0;
    end else begin
      serial_poll_o <= 1'b0;
      if (serial_poll_o) begin
        poll_seen_o  <= poll_byte_i;
        poll_count_o <= poll_count_o + 8'h01;
        wait_reg     <= 4'h0;
      end else if (enable_i && srq_i) begin
        if (wait_reg == pause_i) serial_poll_o <= 1'b1;
        else wait_reg <= wait_reg + 4'h1;
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

// >>> srs_status_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks on the status and request logic
module srs_status_checker
  import srs_pkg::*;
#(
  parameter int EVT_WIDTH = 16
) (
  input wire logic                       clk_i,
  input wire logic                       reset_i,
  input wire logic                       clear_status_i,
  input wire logic                       preset_i,
  input wire logic                       ena_write_i,
  input wire logic                       ese_write_i,
  input wire logic [srs_pkg::ESR_W-1:0]  ese_wdata_i,
  input wire logic                       sre_write_i,
  input wire logic [srs_pkg::STB_W-1:0]  sre_wdata_i,
  input wire logic                       err_push_i,
  input wire logic                       serial_poll_i,
  input wire logic [EVT_WIDTH-1:0]       ena_rdata_o,
  input wire logic [srs_pkg::ESR_W-1:0]  ese_rdata_o,
  input wire logic [srs_pkg::STB_W-1:0]  sre_rdata_o,
  input wire logic [srs_pkg::STB_W-1:0]  stb_query_o,
  input wire logic                       err_full_o,
  input wire logic                       srq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Properties
  property p_rst_clear;
    $fell(reset_i) |-> stb_query_o == '0 && !srq_o && sre_rdata_o == '0
      && ena_rdata_o == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
  property p_sre_write; sre_write_i |=> sre_rdata_o == $past(sre_wdata_i); endproperty
  a_sre_write: assert property (p_sre_write) else $error("mask write lost");
  property p_ese_write; ese_write_i |=> ese_rdata_o == $past(ese_wdata_i); endproperty
  a_ese_write: assert property (p_ese_write) else $error("std enable write lost");
  property p_preset_ena; preset_i && !ena_write_i |-> ##2 ena_rdata_o == '0; endproperty
  a_preset_ena: assert property (p_preset_ena) else $error("preset kept enable");
  property p_preset_ese; preset_i && !ese_write_i |=> $stable(ese_rdata_o); endproperty
  a_preset_ese: assert property (p_preset_ese) else $error("preset hit std enable");
  property p_master;
    ($stable(sre_rdata_o) && $stable(stb_query_o & SUM_MASK)) [*2]
      |-> stb_query_o[6] == |(stb_query_o & SUM_MASK & sre_rdata_o);
  endproperty
  a_master: assert property (p_master) else $error("master summary wrong");
  property p_srq_rise;
    $rose(stb_query_o[6]) && !serial_poll_i && !clear_status_i |-> ##[0:1] srq_o;
  endproperty
  a_srq_rise: assert property (p_srq_rise) else $error("no request on rise");
  property p_poll_clear;
    serial_poll_i && srq_o && !clear_status_i |=> !srq_o || $changed(stb_query_o);
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("poll kept request");
  property p_srq_fall;
    $fell(srq_o) |-> $past(serial_poll_i) || $past(serial_poll_i, 2) || $past(clear_status_i)
      || $past(clear_status_i, 2) || !stb_query_o[6] || !$past(stb_query_o[6]);
  endproperty
  a_srq_fall: assert property (p_srq_fall) else $error("request dropped early");
  property p_err_full; $rose(err_full_o) |-> $past(err_push_i) || $past(err_push_i, 2); endproperty
  a_err_full: assert property (p_err_full) else $error("full without push");
  // Main scenarios
  c_poll: cover property (srq_o ##1 serial_poll_i);
  c_full: cover property (err_full_o);
  c_preset: cover property (preset_i);
endmodule

bind srs_status srs_status_checker #(.EVT_WIDTH(EVT_WIDTH)) chk_u (.clk_i, .reset_i,
  .clear_status_i, .preset_i, .ena_write_i, .ese_write_i, .ese_wdata_i, .sre_write_i,
  .sre_wdata_i, .err_push_i, .serial_poll_i, .ena_rdata_o, .ese_rdata_o, .sre_rdata_o,
  .stb_query_o, .err_full_o, .srq_o);

// >>> status_reporting_srq_logic_test.sv
`timescale 1ns/1ps
// ==========================================================
// Directed bench for the status byte and service request logic
module status_reporting_srq_logic_test;
  import srs_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, clear_status_i = 1'b0, preset_i = 1'b0, evt_read_i = 1'b0;
  logic ena_write_i = 1'b0, ese_write_i = 1'b0, std_read_i = 1'b0, sre_write_i = 1'b0;
  logic out_push_i = 1'b0, out_pop_i = 1'b0, err_push_i = 1'b0, err_pop_i = 1'b0, poll_en = 1'b0;
  logic [15:0] meas_cond_i = 16'h0000, ques_cond_i = 16'h0000, oper_cond_i = 16'h0000;
  logic [15:0] ena_wdata_i = 16'h0000, cond_rdata_o, evt_rdata_o, ena_rdata_o;
  logic [7:0]  std_event_i = 8'h00, ese_wdata_i = 8'h00, sre_wdata_i = 8'h00, out_data_i = 8'h00;
  logic [7:0]  err_data_i = 8'h00, std_evt_rdata_o, ese_rdata_o, sre_rdata_o, stb_query_o;
  logic [7:0]  poll_byte_o, out_rdata_o, err_rdata_o, poll_seen, poll_count;
  logic [1:0]  evt_read_sel_i = 2'h0, ena_sel_i = 2'h0;
  logic [3:0]  poll_pause = 4'h0;
  logic        serial_poll_i, err_full_o, srq_o;
  int          errors = 0, n_checks = 0;

  always #5 clk_i = ~clk_i;

  srs_status dut_u (.clk_i, .reset_i, .clear_status_i, .preset_i, .meas_cond_i, .ques_cond_i,
    .oper_cond_i, .std_event_i, .evt_read_i, .evt_read_sel_i, .ena_write_i, .ena_sel_i,
    .ena_wdata_i, .ese_write_i, .ese_wdata_i, .std_read_i, .sre_write_i, .sre_wdata_i,
    .out_push_i, .out_data_i, .out_pop_i, .err_push_i, .err_data_i, .err_pop_i, .serial_poll_i,
    .cond_rdata_o, .evt_rdata_o, .ena_rdata_o, .std_evt_rdata_o, .ese_rdata_o, .sre_rdata_o,
    .stb_query_o, .poll_byte_o, .out_rdata_o, .err_rdata_o, .err_full_o, .srq_o);
  srs_poll_model pm_u (.clk_i, .reset_i, .enable_i(poll_en), .pause_i(poll_pause),
    .srq_i(srq_o), .poll_byte_i(poll_byte_o), .serial_poll_o(serial_poll_i),
    .poll_seen_o(poll_seen), .poll_count_o(poll_count));

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One-cycle strobe: 0 sre 1 ese 2 ena 3 preset 4 std read 5 clear 6 push 7 pop 8 evt read
  task automatic strobe(input int k, input logic [15:0] v);
    @(posedge clk_i);
    {sre_wdata_i, ese_wdata_i, out_data_i, ena_wdata_i} <= {v[7:0], v[7:0], v[7:0], v};
    case (k)
      0: sre_write_i <= 1'b1;
      1: ese_write_i <= 1'b1;
      2: ena_write_i <= 1'b1;
      3: preset_i <= 1'b1;
      4: std_read_i <= 1'b1;
      5: clear_status_i <= 1'b1;
      6: out_push_i <= 1'b1;
      7: out_pop_i <= 1'b1;
      default: evt_read_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {sre_write_i, ese_write_i, ena_write_i, preset_i, std_read_i} <= 5'h00;
    {clear_status_i, out_push_i, out_pop_i, evt_read_i} <= 4'h0;
    #1;
  endtask
  // Let the controller poll once, prompt or slow
  task automatic do_poll(input logic [3:0] p);
    logic [7:0] c0;
    c0 = poll_count;
    @(posedge clk_i) poll_en <= 1'b1;
    poll_pause <= p;
    for (int i = 0; i < 60 && poll_count == c0; i++) @(posedge clk_i);
    poll_en <= 1'b0;
    if (poll_count == c0) begin
      errors++;
      tally_and_finish();
    end
    tick(3);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    tick(2);
    chk("stb", stb_query_o, 16'h0000);
    chk("sre", sre_rdata_o, 16'h0000);
    chk("ena", ena_rdata_o, 16'h0000);
    @(posedge clk_i) meas_cond_i <= 16'h0001;
    tick(3);
    chk("stb masked", stb_query_o, 16'h0000);
    chk("cond", cond_rdata_o, 16'h0001);
    strobe(0, 16'h0009);
    strobe(2, 16'h0001);
    tick(3);
    chk("sre", sre_rdata_o, 16'h0009);
    chk("ena", ena_rdata_o, 16'h0001);
    chk("stb", stb_query_o, 16'h0041);
    chk("srq", srq_o, 16'h0001);
    do_poll(4'h0);
    chk("poll", poll_seen, 16'h0041);
    chk("srq", srq_o, 16'h0000);
    chk("stb", stb_query_o, 16'h0041);
    @(posedge clk_i) meas_cond_i <= 16'h0000;
    @(posedge clk_i) meas_cond_i <= 16'h0001;
    tick(3);
    chk("srq same", srq_o, 16'h0001);
    do_poll(4'h0);
    chk("poll", poll_seen, 16'h0041);
    chk("srq", srq_o, 16'h0000);
    @(posedge clk_i) ena_sel_i <= 2'h1;
    strobe(2, 16'h0001);
    @(posedge clk_i) ques_cond_i <= 16'h0001;
    tick(3);
    chk("srq again", srq_o, 16'h0001);
    do_poll(4'h6);
    chk("poll", poll_seen, 16'h0049);
    strobe(8, 16'h0000);
    chk("evt", evt_rdata_o, 16'h0001);
    tick(3);
    chk("stb", stb_query_o, 16'h0048);
    strobe(1, 16'h0020);
    strobe(3, 16'h0000);
    tick(3);
    chk("ese", ese_rdata_o, 16'h0020);
    chk("ena", ena_rdata_o, 16'h0000);
    chk("stb", stb_query_o, 16'h0000);
    strobe(1, 16'h0000);
    tick(3);
    chk("ese", ese_rdata_o, 16'h0000);
    strobe(1, 16'h0020);
    @(posedge clk_i) std_event_i <= 8'h20;
    @(posedge clk_i) std_event_i <= 8'h00;
    tick(3);
    chk("stb", stb_query_o, 16'h0020);
    strobe(4, 16'h0000);
    chk("std", std_evt_rdata_o, 16'h0020);
    tick(3);
    chk("stb", stb_query_o, 16'h0000);
    strobe(0, 16'h0014);
    strobe(6, 16'h00A5);
    tick(3);
    chk("stb", stb_query_o, 16'h0050);
    strobe(7, 16'h0000);
    tick(1);
    chk("out", out_rdata_o, 16'h00A5);
    tick(2);
    chk("stb", stb_query_o, 16'h0000);
    chk("srq", srq_o, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i) err_push_i <= 1'b1;
      err_data_i <= 8'h10 + i[7:0];
    end
    @(posedge clk_i) err_push_i <= 1'b0;
    tick(3);
    chk("full", err_full_o, 16'h0001);
    chk("stb", stb_query_o, 16'h0044);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i) err_pop_i <= 1'b1;
      @(posedge clk_i) err_pop_i <= 1'b0;
      tick(1);
      chk("err", err_rdata_o, 16'h0010 + i[15:0]);
    end
    tick(3);
    chk("stb", stb_query_o, 16'h0000);
    chk("full", err_full_o, 16'h0000);
    strobe(6, 16'h003C);
    @(posedge clk_i) std_event_i <= 8'h20;
    @(posedge clk_i) std_event_i <= 8'h00;
    tick(3);
    chk("stb", stb_query_o, 16'h0070);
    strobe(5, 16'h0000);
    tick(3);
    chk("stb", stb_query_o, 16'h0000);
    chk("srq", srq_o, 16'h0000);
    tally_and_finish();
  end
endmodule
